// File: pscp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - A disabled buck channel with bleed on connects its 115 ohm discharge resistor.
// - Both bleed options are on after reset without any host write.
// - Host clears each channel's bleed bit independently; each bit acts alone.
// - Over-temperature indication at 155 C shuts every regulator channel down.
// - Cooling to 130 C ends shutdown; channels restart through soft-start.
// - Device is a bus target only, answering address 1101000.
// - Address byte bit 0: 0 writes the device, 1 reads it.
// - Bus bit rate up to 400 kb/s; host never clocks faster.
// - Supports register write, read with register address, read without one.
// - Every control register takes its reset value at start-up.
// - Buck one voltage code at address 0x00, buck two at 0x01.
// - Voltage registers: 7-bit code in bits 6..0, bit 7 zero, reset 0x10.
// - Code maps linearly from 0.825 V in 25 mV steps to 3.600 V.
// - Bleed enables are bits 2 and 3 of register 0x04, reset to one.
// - Channel enable bits in register 0x05; zero disables the channel.
module pscp_serial_port
	import pscp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       serial_clock_pin,
	input  wire logic       serial_data_pin_in,
	output logic            serial_data_pin_out,
	output logic            serial_data_pin_oe,
	input  wire logic       temp_trip_high,
	input  wire logic       temp_below_low,
	output logic            buck_channel_one_run,
	output logic            buck_channel_two_run,
	output logic            buck_channel_one_bleed,
	output logic            buck_channel_two_bleed,
	output logic      [6:0] buck_one_voltage_code_out,
	output logic      [6:0] buck_two_voltage_code_out,
	output logic            thermal_shutdown,
	output logic            soft_start_request
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [1:0] hot_sync;
	logic [1:0] cool_sync;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_sync  <= 3'h7;
			sda_sync  <= 3'h7;
			hot_sync  <= 2'h0;
			cool_sync <= 2'h0;
		end else begin
			scl_sync  <= {scl_sync[1:0], serial_clock_pin};
			sda_sync  <= {sda_sync[1:0], serial_data_pin_in};
			hot_sync  <= {hot_sync[0], temp_trip_high};
			cool_sync <= {cool_sync[0], temp_below_low};
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_bit;

	// Stage 1 and 2 are synchronised, stage 2 vs stage 3 finds edges
	assign sda_bit   = sda_sync[1];
	assign scl_rise  = scl_sync[1] & ~scl_sync[2];
	assign scl_fall  = ~scl_sync[1] & scl_sync[2];
	assign bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
	assign bus_stop  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] rd_data;
	logic [7:0] reg_one;
	logic [7:0] reg_two;
	logic [7:0] reg_param;
	logic [7:0] reg_sys;
	logic       wr_en;
	logic [7:0] ptr;
	logic [7:0] shreg;

	pscp_regfile u_regfile (
		.sys_clk                      (sys_clk),
		.rst_n                        (rst_n),
		.wr_en                        (wr_en),
		.wr_addr                      (ptr),
		.wr_data                      (shreg),
		.rd_addr                      (ptr),
		.rd_data                      (rd_data),
		.buck_one_voltage_code        (reg_one),
		.buck_two_voltage_code        (reg_two),
		.converter_parameter_register (reg_param),
		.system_control_register      (reg_sys)
	);

	// ----------------------------------------
	// Serial target state machine
	// ----------------------------------------
	pscp_state_t state;
	pscp_state_t next_state;
	logic [3:0]  bit_cnt;
	logic [3:0]  next_bit_cnt;
	logic [7:0]  next_shreg;
	logic [7:0]  next_ptr;
	logic        is_read;
	logic        next_is_read;
	logic        nack;
	logic        next_nack;
	logic        sda_low;
	logic        next_sda_low;
	logic        next_wr_en;

	always_comb begin
		next_state   = state;
		next_bit_cnt = bit_cnt;
		next_shreg   = shreg;
		next_ptr     = ptr;
		next_is_read = is_read;
		next_nack    = nack;
		next_sda_low = sda_low;
		next_wr_en   = 1'b0;
		if (wr_en) begin
			next_ptr = pscp_next_ptr(ptr);
		end
		if (bus_start) begin
			next_state   = PSCP_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_low = 1'b0;
		end else if (bus_stop) begin
			next_state   = PSCP_IDLE;
			next_sda_low = 1'b0;
		end else if (scl_rise) begin
			unique case (state)
				PSCP_ADDR, PSCP_REG, PSCP_WDATA: begin
					next_shreg   = {shreg[6:0], sda_bit};
					next_bit_cnt = bit_cnt + 4'h1;
				end
				PSCP_RDATA: next_bit_cnt = bit_cnt + 4'h1;
				PSCP_RACK:  next_nack    = sda_bit;
				default:    next_nack    = nack;
			endcase
		end else if (scl_fall) begin
			unique case (state)
				PSCP_ADDR: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						if (shreg[7:1] == TARGET_ADDRESS) begin
							next_is_read = (shreg[0] == DIR_READ);
							next_sda_low = 1'b1;
							next_state   = PSCP_ADDR_ACK;
						end else begin
							next_state = PSCP_IDLE;
						end
					end
				end
				PSCP_ADDR_ACK: begin
					next_bit_cnt = 4'h0;
					if (is_read) begin
						// Read without a register address uses the old pointer
						next_sda_low = ~rd_data[7];
						next_shreg   = {rd_data[6:0], 1'b0};
						next_state   = PSCP_RDATA;
					end else begin
						next_sda_low = 1'b0;
						next_state   = PSCP_REG;
					end
				end
				PSCP_REG: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						next_ptr     = shreg;
						next_sda_low = 1'b1;
						next_state   = PSCP_REG_ACK;
					end
				end
				PSCP_REG_ACK, PSCP_WDATA_ACK: begin
					next_sda_low = 1'b0;
					next_bit_cnt = 4'h0;
					next_state   = PSCP_WDATA;
				end
				PSCP_WDATA: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						next_wr_en   = 1'b1;
						next_sda_low = 1'b1;
						next_state   = PSCP_WDATA_ACK;
					end
				end
				PSCP_RDATA: begin
					if (bit_cnt == BITS_PER_BYTE) begin
						next_sda_low = 1'b0;
						next_ptr     = pscp_next_ptr(ptr);
						next_state   = PSCP_RACK;
					end else begin
						next_sda_low = ~shreg[7];
						next_shreg   = {shreg[6:0], 1'b0};
					end
				end
				PSCP_RACK: begin
					next_bit_cnt = 4'h0;
					if (nack) begin
						next_state = PSCP_IDLE;
					end else begin
						next_sda_low = ~rd_data[7];
						next_shreg   = {rd_data[6:0], 1'b0};
						next_state   = PSCP_RDATA;
					end
				end
				default: next_sda_low = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state   <= PSCP_IDLE;
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			ptr     <= 8'h00;
			is_read <= 1'b0;
			nack    <= 1'b0;
			sda_low <= 1'b0;
			wr_en   <= 1'b0;
		end else begin
			state   <= next_state;
			bit_cnt <= next_bit_cnt;
			shreg   <= next_shreg;
			ptr     <= next_ptr;
			is_read <= next_is_read;
			nack    <= next_nack;
			sda_low <= next_sda_low;
			wr_en   <= next_wr_en;
		end
	end

	assign serial_data_pin_out = 1'b0;
	assign serial_data_pin_oe  = sda_low;

	// ----------------------------------------
	// Thermal shutdown and channel outputs
	// ----------------------------------------
	logic next_shutdown;
	logic next_soft_start;
	logic next_one_run;
	logic next_two_run;

	always_comb begin
		next_shutdown   = thermal_shutdown;
		next_soft_start = 1'b0;
		if (hot_sync[1]) begin
			next_shutdown = 1'b1;
		end else if (thermal_shutdown && cool_sync[1]) begin
			next_shutdown   = 1'b0;
			next_soft_start = 1'b1;
		end
		next_one_run = reg_sys[BUCK_ONE_CHANNEL_ENABLE_BIT] & ~next_shutdown;
		next_two_run = reg_sys[BUCK_TWO_CHANNEL_ENABLE_BIT] & ~next_shutdown;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			thermal_shutdown          <= 1'b0;
			soft_start_request        <= 1'b0;
			buck_channel_one_run      <= 1'b0;
			buck_channel_two_run      <= 1'b0;
			buck_channel_one_bleed    <= 1'b0;
			buck_channel_two_bleed    <= 1'b0;
			buck_one_voltage_code_out <= BUCK_VOLTAGE_CODE_RESET[6:0];
			buck_two_voltage_code_out <= BUCK_VOLTAGE_CODE_RESET[6:0];
		end else begin
			thermal_shutdown          <= next_shutdown;
			soft_start_request        <= next_soft_start;
			buck_channel_one_run      <= next_one_run;
			buck_channel_two_run      <= next_two_run;
			buck_channel_one_bleed    <= ~next_one_run & reg_param[BUCK_ONE_BLEED_ENABLE_BIT];
			buck_channel_two_bleed    <= ~next_two_run & reg_param[BUCK_TWO_BLEED_ENABLE_BIT];
			buck_one_voltage_code_out <= reg_one[6:0];
			buck_two_voltage_code_out <= reg_two[6:0];
		end
	end

endmodule // pscp_serial_port
`default_nettype wire

// File: pscp_pkg.sv
`default_nettype none
package pscp_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] BUCK_ONE_VOLTAGE_CODE_ADDR        = 8'h00;
	localparam logic [7:0] BUCK_TWO_VOLTAGE_CODE_ADDR        = 8'h01;
	localparam logic [7:0] CONVERTER_PARAMETER_REGISTER_ADDR = 8'h04;
	localparam logic [7:0] SYSTEM_CONTROL_REGISTER_ADDR      = 8'h05;

	localparam logic [7:0] BUCK_VOLTAGE_CODE_RESET           = 8'h10;
	localparam logic [7:0] CONVERTER_PARAMETER_RESET         = 8'h0f;
	localparam logic [7:0] SYSTEM_CONTROL_RESET              = 8'h2f;
	localparam logic [7:0] WRITABLE_BITS_MASK                = 8'h7f;
	localparam logic [7:0] UNMAPPED_READ_VALUE               = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BUCK_ONE_BLEED_ENABLE_BIT   = 2;
	localparam int BUCK_TWO_BLEED_ENABLE_BIT   = 3;
	localparam int BUCK_ONE_CHANNEL_ENABLE_BIT = 0;
	localparam int BUCK_TWO_CHANNEL_ENABLE_BIT = 1;

	// ----------------------------------------
	// Serial target
	// ----------------------------------------
	localparam logic [6:0] TARGET_ADDRESS   = 7'h68;
	localparam logic [0:0] DIR_READ         = 1'h1;
	localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
	localparam int         MAX_BIT_RATE_KBS = 400;
	localparam int         SYS_CLK_MHZ      = 50;
	localparam int         SCL_MIN_CYCLES   = (SYS_CLK_MHZ * 1000) / MAX_BIT_RATE_KBS;

	typedef enum logic [8:0] {
		PSCP_IDLE      = 9'h001,
		PSCP_ADDR      = 9'h002,
		PSCP_ADDR_ACK  = 9'h004,
		PSCP_REG       = 9'h008,
		PSCP_REG_ACK   = 9'h010,
		PSCP_WDATA     = 9'h020,
		PSCP_WDATA_ACK = 9'h040,
		PSCP_RDATA     = 9'h080,
		PSCP_RACK      = 9'h100
	} pscp_state_t;

	function automatic logic [7:0] pscp_next_ptr(input logic [7:0] ptr);
		pscp_next_ptr = ptr + 8'h01;
	endfunction

endpackage
`default_nettype wire

// File: pscp_regfile.sv
`timescale 1ns/1ns
`default_nettype none
module pscp_regfile
	import pscp_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	output logic      [7:0] buck_one_voltage_code,
	output logic      [7:0] buck_two_voltage_code,
	output logic      [7:0] converter_parameter_register,
	output logic      [7:0] system_control_register
);

	logic [7:0] next_rd_data;
	logic [7:0] next_one;
	logic [7:0] next_two;
	logic [7:0] next_param;
	logic [7:0] next_sys;
	logic [7:0] wval;

	// ----------------------------------------
	// Write decode and registered read
	// ----------------------------------------
	always_comb begin
		wval       = wr_data & WRITABLE_BITS_MASK;
		next_one   = buck_one_voltage_code;
		next_two   = buck_two_voltage_code;
		next_param = converter_parameter_register;
		next_sys   = system_control_register;
		if (wr_en) begin
			unique case (wr_addr)
				BUCK_ONE_VOLTAGE_CODE_ADDR:        next_one   = wval;
				BUCK_TWO_VOLTAGE_CODE_ADDR:        next_two   = wval;
				CONVERTER_PARAMETER_REGISTER_ADDR: next_param = wval;
				SYSTEM_CONTROL_REGISTER_ADDR:      next_sys   = wval;
				default:                           next_one   = buck_one_voltage_code;
			endcase
		end
		unique case (rd_addr)
			BUCK_ONE_VOLTAGE_CODE_ADDR:        next_rd_data = buck_one_voltage_code;
			BUCK_TWO_VOLTAGE_CODE_ADDR:        next_rd_data = buck_two_voltage_code;
			CONVERTER_PARAMETER_REGISTER_ADDR: next_rd_data = converter_parameter_register;
			SYSTEM_CONTROL_REGISTER_ADDR:      next_rd_data = system_control_register;
			default:                           next_rd_data = UNMAPPED_READ_VALUE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			buck_one_voltage_code        <= BUCK_VOLTAGE_CODE_RESET;
			buck_two_voltage_code        <= BUCK_VOLTAGE_CODE_RESET;
			converter_parameter_register <= CONVERTER_PARAMETER_RESET;
			system_control_register      <= SYSTEM_CONTROL_RESET;
			rd_data                      <= UNMAPPED_READ_VALUE;
		end else begin
			buck_one_voltage_code        <= next_one;
			buck_two_voltage_code        <= next_two;
			converter_parameter_register <= next_param;
			system_control_register      <= next_sys;
			rd_data                      <= next_rd_data;
		end
	end

endmodule // pscp_regfile
`default_nettype wire

// File: pscp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pscp_host_model (
	input  wire logic sys_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Quarter bit time, about 390 kb/s
	localparam int Q = 32;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic q();
		repeat (Q) @(posedge sys_clk);
	endtask

	// Start or repeated start
	task automatic start();
		sda_low <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_low <= 1'b0;
		q();
	endtask

	// Nine bits MSB first, last is the ack slot
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_low <= ~tx[i];
			q();
			scl <= 1'b1;
			q();
			rx[i] = sda;
			q();
			scl <= 1'b0;
			q();
		end
	endtask
endmodule // pscp_host_model
`default_nettype wire

// File: pscp_serial_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pscp_serial_port_checker
	import pscp_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       serial_clock_pin,
	input wire logic       serial_data_pin_in,
	input wire logic       serial_data_pin_out,
	input wire logic       serial_data_pin_oe,
	input wire logic       temp_trip_high,
	input wire logic       temp_below_low,
	input wire logic       buck_channel_one_run,
	input wire logic       buck_channel_two_run,
	input wire logic       buck_channel_one_bleed,
	input wire logic       buck_channel_two_bleed,
	input wire logic [6:0] buck_one_voltage_code_out,
	input wire logic [6:0] buck_two_voltage_code_out,
	input wire logic       thermal_shutdown,
	input wire logic       soft_start_request
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	bleed_one_a: assert property (buck_channel_one_run
		|-> !buck_channel_one_bleed) else $error("ch1 bleeds while running");
	bleed_two_a: assert property (buck_channel_two_run
		|-> !buck_channel_two_bleed) else $error("ch2 bleeds while running");
	shutdown_off_a: assert property (thermal_shutdown
		|-> !buck_channel_one_run && !buck_channel_two_run) else $error("run in shutdown");
	trip_shutdown_a: assert property ($rose(temp_trip_high)
		|-> ##[1:5] thermal_shutdown) else $error("no shutdown on trip");
	cool_release_a: assert property ($rose(temp_below_low) && thermal_shutdown && !temp_trip_high
		|-> ##[1:5] !thermal_shutdown) else $error("no restart on cooling");
	restart_soft_a: assert property ($fell(thermal_shutdown)
		|-> ##[0:1] soft_start_request) else $error("restart without soft start");
	soft_pulse_a: assert property (soft_start_request
		|=> !soft_start_request) else $error("soft start too long");
	ack_timing_a: assert property ($changed(serial_data_pin_oe)
		|-> !serial_clock_pin) else $error("data moved with clock high");
	code_update_a: assert property ($changed(buck_one_voltage_code_out)
		|-> !serial_clock_pin) else $error("code moved mid bit");
endmodule // pscp_serial_port_checker

bind pscp_serial_port pscp_serial_port_checker u_pscp_serial_port_checker (.*);
`default_nettype wire

// File: pscp_serial_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pscp_serial_port_bench;
	import pscp_pkg::*;
	logic            sys_clk = 1'b0;
	logic            rst_n = 1'b0;
	logic            temp_trip_high = 1'b0;
	logic            temp_below_low = 1'b0;
	wire logic       scl, hlow, oe, dout, sda, r1, r2, b1, b2, sd, ss;
	wire logic [6:0] c1, c2;
	wire logic [7:0] st;
	int              err_count = 0;
	int              num_checks = 0;
	int              cyc = 0;
	int              ss_seen = 0;

	assign sda = (oe ? dout : 1'b1) & ~hlow;
	assign st = {r1, r2, b1, b2, sd, 3'h0};
	always #10 sys_clk = ~sys_clk;

	pscp_serial_port u_pscp_serial_port (.sys_clk(sys_clk), .rst_n(rst_n),
		.serial_clock_pin(scl), .serial_data_pin_in(sda), .serial_data_pin_out(dout),
		.serial_data_pin_oe(oe), .temp_trip_high(temp_trip_high),
		.temp_below_low(temp_below_low), .buck_channel_one_run(r1),
		.buck_channel_two_run(r2), .buck_channel_one_bleed(b1), .buck_channel_two_bleed(b2),
		.buck_one_voltage_code_out(c1), .buck_two_voltage_code_out(c2),
		.thermal_shutdown(sd), .soft_start_request(ss));
	pscp_host_model h (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(hlow));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (ss === 1'b1) ss_seen <= ss_seen + 1;
		if (cyc == 80000) begin
			err_count++;
			results();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic snd(input logic [7:0] d);
		logic [8:0] rx;
		h.xfer({d, 1'b1}, rx);
		chk({7'h0, rx[0]}, 8'h00);
	endtask

	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		h.start();
		snd({TARGET_ADDRESS, 1'b0});
		snd(ra);
		snd(d);
		h.stop();
	endtask

	task automatic rd(input logic sel, input logic [7:0] ra, input logic [7:0] exp);
		logic [8:0] rx;
		if (sel) begin
			h.start();
			snd({TARGET_ADDRESS, 1'b0});
			snd(ra);
		end
		h.start();
		snd({TARGET_ADDRESS, DIR_READ});
		h.xfer(9'h1ff, rx);
		h.stop();
		chk(rx[8:1], exp);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [8:0] rx;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(st, 8'hc0);
		chk({1'b0, c1}, 8'h10);
		chk({1'b0, c2}, 8'h10);
		$display("test reset done");

		wr(8'h00, 8'h6f);
		chk({1'b0, c1}, 8'h6f);
		wr(8'h01, 8'hff);
		chk({1'b0, c2}, 8'h7f);
		rd(1'b1, 8'h00, 8'h6f);
		rd(1'b0, 8'h00, 8'h7f);
		rd(1'b1, 8'h04, 8'h0f);
		rd(1'b1, 8'h05, 8'h2f);
		h.start();
		h.xfer({TARGET_ADDRESS ^ 7'h01, 2'b01}, rx);
		h.stop();
		chk({7'h0, rx[0]}, 8'h01);
		h.start();
		snd({TARGET_ADDRESS, 1'b0});
		snd(8'h00);
		snd(8'h12);
		snd(8'h34);
		h.stop();
		chk({1'b0, c1}, 8'h12);
		chk({1'b0, c2}, 8'h34);
		h.start();
		snd({TARGET_ADDRESS, 1'b0});
		snd(8'h00);
		h.start();
		snd({TARGET_ADDRESS, DIR_READ});
		h.xfer(9'h1fe, rx);
		chk(rx[8:1], 8'h12);
		h.xfer(9'h1ff, rx);
		h.stop();
		chk(rx[8:1], 8'h34);
		rd(1'b0, 8'h00, 8'h00);
		$display("test serial done");

		wr(8'h05, 8'h2c);
		chk(st, 8'h30);
		wr(8'h04, 8'h0b);
		chk(st, 8'h10);
		wr(8'h05, 8'h2f);
		chk(st, 8'hc0);
		$display("test bleed done");

		temp_trip_high <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(st, 8'h18);
		temp_trip_high <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk(st, 8'h18);
		temp_below_low <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(st, 8'hc0);
		chk(8'(ss_seen), 8'h01);
		$display("test thermal done");
		results();
	end
endmodule // pscp_serial_port_bench
`default_nettype wire
